// *** design/umcl_cfg.svh ***
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the modem control block only
`ifndef UMCL_CFG_SVH
`define UMCL_CFG_SVH
`define UMCL_OFS_IER       3'h1
`define UMCL_OFS_LSR       3'h5
`define UMCL_OFS_MCR       3'h4
`define UMCL_OFS_MSR       3'h6
`define UMCL_OFS_TXCTL     3'h7
`define UMCL_IER_RST       8'h00
`define UMCL_MCR_RST       8'h00
`define UMCL_IER_MASK      8'h0F
`define UMCL_MCR_MASK      8'h1F
`define UMCL_MCR_LOOP      4
`define UMCL_IER_MS        3
`define UMCL_IER_TX        1
`define UMCL_BAUD_DIV      16'h0010
`define UMCL_STOP_INT_BAUD 8
`define UMCL_START_BAUD    16
`define UMCL_FIRST_INT_BAUD 24
`endif

// *** design/umcl_pkg.sv ***
// Types shared by the modem control block
// Assumes the constants header sits beside it
package umcl_pkg;
  // Modem pins, active low as on the connector
  typedef struct packed {
    logic clear_to_send_n;
    logic set_ready_n;
    logic ring_n;
    logic carrier_detect_input_n;
  } umcl_modem_in_t;
  typedef struct packed {
    logic terminal_ready_n;
    logic request_to_send_n;
    logic aux1_n;
    logic aux2_n;
  } umcl_modem_out_t;
  // Transmit pacing states
  typedef enum logic [2:0] {
    UMCL_IDLE  = 3'b001,
    UMCL_START = 3'b010,
    UMCL_SEND  = 3'b100
  } umcl_tx_state_t;
endpackage

// *** design/umcl_modem_ctrl.sv ***
// Modem control, loopback and modem status with transmit pacing
// Assumes one 100 MHz clock and a host port with one-cycle strobes
//
// Decided for this implementation: the register offsets and the plain strobed port.
`include "umcl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module umcl_modem_ctrl #(
  parameter int BAUD_DIV = `UMCL_BAUD_DIV  // Clock cycles per baud tick
) (
  input  wire logic                     clk_in,          // 100 MHz clock
  input  wire logic                     rst_n_in,        // Sync reset, low
  input  wire logic [2:0]               addr_in,         // Register address
  input  wire logic [7:0]               wdata_in,        // Write data
  input  wire logic                     wr_in,           // Write strobe
  input  wire logic                     rd_in,           // Read strobe
  output logic      [7:0]               rdata_out,       // Read data
  input  wire umcl_pkg::umcl_modem_in_t modem_in,        // Modem pins
  output umcl_pkg::umcl_modem_out_t     modem_out,       // Handshake pins
  input  wire logic                     tx_shift_in,     // Transmit shifter bit
  input  wire logic                     serial_rx_pin_in,// Serial input pin
  output logic                          rx_shift_out,    // Receiver input bit
  output logic                          serial_tx_pin_out, // Serial out level
  output logic                          serial_tx_oe_out,  // Serial out enable
  input  wire logic                     stop_done_in,    // Stop bit finished
  output logic                          tx_start_out,    // Begin start bit
  output logic                          baud_clock_out,  // Baud tick
  output logic                          interrupt_out    // Interrupt, high
);
  import umcl_pkg::*;

  initial begin
    if (BAUD_DIV < 2 || BAUD_DIV > 65535) begin
      $error("BAUD_DIV out of range");
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers
  logic [3:0] ier;             // Interrupt enables
  logic [4:0] modem_control;             // Modem control
  logic [3:0] msr_chg;         // Change indicators
  logic [3:0] prev_lines;      // Previous effective lines (true sense)
  logic       txe_flag;        // Holding-empty interrupt flag
  logic       loop;            // Loopback active
  logic [3:0] lines;           // Effective modem lines, true sense
  logic [3:0] next_chg;        // Next change bits
  logic       ms_irq;          // Modem status request

  assign loop = modem_control[`UMCL_MCR_LOOP];

  // Effective lines ordered {carrier, ring, ready, clear}
  always_comb begin
    if (loop) begin
      lines = {modem_control[3], modem_control[2], modem_control[0], modem_control[1]};
    end else begin
      lines = ~{modem_in.carrier_detect_input_n, modem_in.ring_n,
                modem_in.set_ready_n, modem_in.clear_to_send_n};
    end
  end

  // Pins: a 1 in a bit pulls its pin low
  always_comb begin
    modem_out.terminal_ready_n  = ~modem_control[0];
    modem_out.request_to_send_n = ~modem_control[1];
    modem_out.aux1_n            = ~modem_control[2];
    modem_out.aux2_n            = ~modem_control[3];
  end

  // Serial path switching
  always_comb begin
    serial_tx_pin_out = tx_shift_in;
    serial_tx_oe_out  = ~loop;
    rx_shift_out      = loop ? tx_shift_in : serial_rx_pin_in;
  end

  //////////////////////////////////////////////////////////////////////////
  // Enable and control registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ier <= 4'h0;
      modem_control <= 5'h00;
    end else if (wr_in) begin
      if (addr_in == `UMCL_OFS_IER) begin
        ier <= wdata_in[3:0];
      end else if (addr_in == `UMCL_OFS_MCR) begin
        modem_control <= wdata_in[4:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Change detection; a set in the read cycle survives the clear
  always_comb begin
    next_chg = msr_chg;
    if (rd_in && addr_in == `UMCL_OFS_MSR) begin
      next_chg = 4'h0;
    end
    next_chg[0] = next_chg[0] | (lines[0] ^ prev_lines[0]);
    next_chg[1] = next_chg[1] | (lines[1] ^ prev_lines[1]);
    next_chg[2] = next_chg[2] | (prev_lines[2] & ~lines[2]);
    next_chg[3] = next_chg[3] | (lines[3] ^ prev_lines[3]);
    if (loop && wr_in && addr_in == `UMCL_OFS_MSR) begin
      next_chg = next_chg | wdata_in[3:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      msr_chg    <= 4'h0;
      prev_lines <= 4'h0;
    end else begin
      msr_chg    <= next_chg;
      prev_lines <= lines;
    end
  end

  // Lowest priority source; enable bit gates it
  assign ms_irq = ier[`UMCL_IER_MS] & (|msr_chg);

  //////////////////////////////////////////////////////////////////////////
  // Baud tick divider
  logic [15:0] baud_cnt;  // Divider count
  logic        baud_tick; // One-cycle tick
  assign baud_tick = (baud_cnt == 16'(BAUD_DIV - 1));
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      baud_cnt       <= 16'h0000;
      baud_clock_out <= 1'b0;
    end else begin
      baud_cnt       <= baud_tick ? 16'h0000 : baud_cnt + 16'h0001;
      baud_clock_out <= baud_tick;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit pacing: write to control address 7 marks a holding write
  umcl_tx_state_t tx_state;  // Pacing state
  logic [4:0]     tx_cnt;    // Baud ticks counted
  logic           thr_wr;    // Holding register write
  logic           stop_wait; // Counting after stop
  assign thr_wr = wr_in && addr_in == `UMCL_OFS_TXCTL;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_state     <= UMCL_IDLE;
      tx_cnt       <= 5'h00;
      txe_flag     <= 1'b0;
      tx_start_out <= 1'b0;
      stop_wait    <= 1'b0;
    end else begin
      tx_start_out <= 1'b0;
      if (thr_wr) begin
        txe_flag <= 1'b0;
      end
      if (loop && wr_in && addr_in == `UMCL_OFS_LSR && wdata_in[5]) begin
        txe_flag <= 1'b1;
      end
      case (tx_state)
        UMCL_IDLE: begin
          if (thr_wr) begin
            tx_state <= UMCL_START;
            tx_cnt   <= 5'h00;
          end
        end
        UMCL_START: begin
          if (baud_tick) begin
            tx_cnt <= tx_cnt + 5'h01;
            if (tx_cnt == 5'(`UMCL_START_BAUD - 1)) begin
              tx_start_out <= 1'b1;
            end
            if (tx_cnt == 5'(`UMCL_FIRST_INT_BAUD - 1)) begin
              txe_flag <= 1'b1;
              tx_state <= UMCL_SEND;
              tx_cnt   <= 5'h00;
            end
          end
        end
        UMCL_SEND: begin
          if (stop_done_in) begin
            stop_wait <= 1'b1;
            tx_cnt    <= 5'h00;
          end else if (stop_wait && baud_tick) begin
            tx_cnt <= tx_cnt + 5'h01;
            if (tx_cnt == 5'(`UMCL_STOP_INT_BAUD - 1)) begin
              txe_flag  <= 1'b1;
              stop_wait <= 1'b0;
              tx_state  <= UMCL_IDLE;
            end
          end
        end
        default: tx_state <= UMCL_IDLE;
      endcase
    end
  end

  // Active high, quiet when all enables are clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      interrupt_out <= 1'b0;
    end else begin
      interrupt_out <= ms_irq | (ier[`UMCL_IER_TX] & txe_flag);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      if (addr_in == `UMCL_OFS_IER) begin
        rdata_out <= {4'h0, ier};
      end else if (addr_in == `UMCL_OFS_MCR) begin
        rdata_out <= {3'h0, modem_control};
      end else if (addr_in == `UMCL_OFS_MSR) begin
        rdata_out <= {lines[3], lines[2], lines[1], lines[0], msr_chg};
      end else if (addr_in == `UMCL_OFS_LSR) begin
        rdata_out <= {2'h0, txe_flag, 5'h00};
      end else begin
        rdata_out <= 8'h00;
      end
    end else begin
      rdata_out <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  // Handshake pins follow the control bits, inverted
  dtr_pin_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    modem_out.terminal_ready_n == ~modem_control[0])
    else $error("terminal ready wrong");
  rts_pin_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    modem_out.request_to_send_n == ~modem_control[1])
    else $error("send request wrong");
  aux_pins_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    {modem_out.aux2_n, modem_out.aux1_n} == ~modem_control[3:2])
    else $error("aux pins wrong");

  // Unused register bits always read as zero
  ier_zero_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == `UMCL_OFS_IER |=> rdata_out[7:4] == 4'h0)
    else $error("ier high bits");
  mcr_zero_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == `UMCL_OFS_MCR |=> rdata_out[7:5] == 3'h0)
    else $error("mcr high bits");

  // Serial and modem line switching
  loop_float_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    loop |-> !serial_tx_oe_out && rx_shift_out == tx_shift_in)
    else $error("loop path");
  rx_path_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !loop |-> serial_tx_oe_out && rx_shift_out == serial_rx_pin_in)
    else $error("normal serial path");
  line_map_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !loop |-> lines == ~{modem_in.carrier_detect_input_n, modem_in.ring_n,
                         modem_in.set_ready_n, modem_in.clear_to_send_n})
    else $error("pin map wrong");
  loop_map_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    loop |-> lines == {modem_control[3], modem_control[2], modem_control[0], modem_control[1]})
    else $error("loop map");

  // Change indicators: set on change, ring on its trailing edge only; cleared by a status read
  cts_change_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    lines[0] != prev_lines[0] |=> msr_chg[0])
    else $error("send change missed");
  carrier_change_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    lines[3] != prev_lines[3] |=> msr_chg[3])
    else $error("carrier change missed");
  ring_set_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    prev_lines[2] && !lines[2] |=> msr_chg[2])
    else $error("ring trailing edge missed");
  ring_edge_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !msr_chg[2] && !$fell(lines[2]) && !(loop && wr_in) |=> !msr_chg[2])
    else $error("ring change wrong");
  chg_clear_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == `UMCL_OFS_MSR && lines == prev_lines |=> msr_chg == 4'h0)
    else $error("change not cleared");
  host_set_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    loop && wr_in && addr_in == `UMCL_OFS_MSR |=>
      (msr_chg & $past(wdata_in[3:0])) == $past(wdata_in[3:0]))
    else $error("host status write lost");
  status_read_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == `UMCL_OFS_MSR |=> rdata_out[7:4] == $past(lines))
    else $error("line levels wrong");

  // Interrupt output
  ms_irq_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ier[3] && |msr_chg |=> interrupt_out)
    else $error("modem irq missing");
  ms_gate_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !ier[3] && !(ier[1] && txe_flag) |=> !interrupt_out)
    else $error("modem irq not gated");
  irq_off_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ier == 4'h0 |=> !interrupt_out)
    else $error("irq while disabled");
  txe_clr_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    tx_state == UMCL_IDLE && thr_wr |=> !txe_flag)
    else $error("holding flag not cleared");

  // Main scenarios reached
  loop_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(loop));
  irq_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(interrupt_out));
  start_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) tx_start_out);
  ring_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(msr_chg[2]));
  host_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    loop && wr_in && addr_in == `UMCL_OFS_MSR);
endmodule
`default_nettype wire

// *** tb/umcl_modem_model.sv ***
// Modem partner: drives the handshake pins and the serial input line
// Assumes the bench sets wanted levels by non-blocking assignment
`timescale 1ns/1ps
`default_nettype none
module umcl_modem_model
  import umcl_pkg::*;
#(
  parameter int LAG = 2  // Delay tap 0..7; pin lags the command by LAG+1 cycles
) (
  input  wire logic                clk_in,    // Bench clock
  input  wire logic [3:0]          on_in,     // Wanted on: cts,dsr,ri,dcd
  input  wire logic                rx_in,     // Wanted serial level
  output umcl_pkg::umcl_modem_in_t modem_out, // Pins, low when on
  output logic                     rx_out     // Serial line
);
  logic [3:0] hist [0:7];  // Delay line for slow answers
  // Shift the wanted levels along so pins lag the command
  always_ff @(posedge clk_in) begin
    hist[0] <= on_in;
    for (int i = 1; i < 8; i++) begin
      hist[i] <= hist[i-1];
    end
  end
  // Pins are active low; the serial line is always driven
  assign modem_out = umcl_modem_in_t'(~hist[LAG]);
  assign rx_out    = rx_in;
endmodule
`default_nettype wire

// *** tb/uart_modem_control_loopback_tb_top.sv ***
// Self-checking bench for the modem control block
// Assumes the design package and the modem partner are compiled first
`timescale 1ns/1ps
`default_nettype none
module uart_modem_control_loopback_tb_top;
  import umcl_pkg::*;
  typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] r; logic [3:0] o;} umcl_row_t;
  logic clk_in, rst_n_in, wr_in, rd_in, tx_shift_in, stop_done_in, rx_cmd, rx_line;
  logic [2:0] addr_in;
  logic [7:0] wdata_in, rdata_out, rd_val;
  logic [3:0] on_cmd;
  logic rx_shift_out, serial_tx_pin_out, serial_tx_oe_out, tx_start_out, baud_clock_out;
  logic interrupt_out;
  umcl_modem_in_t  modem_in;
  umcl_modem_out_t modem_out;
  int errors, checks_done, cycles, ticks, d;
  // Register rows: address, write, readback, handshake pins
  umcl_row_t regs [8] = '{'{3'h4, 8'h01, 8'h01, 4'h7}, '{3'h4, 8'h02, 8'h02, 4'hB},
    '{3'h4, 8'h04, 8'h04, 4'hD}, '{3'h4, 8'h08, 8'h08, 4'hE}, '{3'h4, 8'hE6, 8'h06, 4'h9},
    '{3'h1, 8'hFF, 8'h0F, 4'h9}, '{3'h1, 8'h00, 8'h00, 4'h9}, '{3'h4, 8'h00, 8'h00, 4'hF}};
  // Status rows: 0 = modem lines, 4 = control write; value; status seen
  umcl_row_t modem_status [10] = '{'{3'h0, 8'h08, 8'h11, 4'h0}, '{3'h0, 8'h0C, 8'h32, 4'h0},
    '{3'h0, 8'h0D, 8'hB8, 4'h0}, '{3'h0, 8'h0F, 8'hF0, 4'h0}, '{3'h0, 8'h0D, 8'hB4, 4'h0},
    '{3'h0, 8'h0F, 8'hF0, 4'h0}, '{3'h4, 8'h11, 8'h2D, 4'h0}, '{3'h4, 8'h12, 8'h13, 4'h0},
    '{3'h4, 8'h14, 8'h41, 4'h0}, '{3'h4, 8'h18, 8'h8C, 4'h0}};
  umcl_modem_ctrl #(.BAUD_DIV(2)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .modem_in(modem_in), .modem_out(modem_out),
    .tx_shift_in(tx_shift_in), .serial_rx_pin_in(rx_line), .rx_shift_out(rx_shift_out),
    .serial_tx_pin_out(serial_tx_pin_out), .serial_tx_oe_out(serial_tx_oe_out),
    .stop_done_in(stop_done_in), .tx_start_out(tx_start_out),
    .baud_clock_out(baud_clock_out), .interrupt_out(interrupt_out));
  umcl_modem_model #(.LAG(2)) i_modem (.clk_in(clk_in), .on_in(on_cmd), .rx_in(rx_cmd),
    .modem_out(modem_in), .rx_out(rx_line));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, baud tick counter and hang guard
  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (baud_clock_out === 1'h1) ticks++;
    if (cycles == 4000) begin
      errors++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr_in <= 1'h1; addr_in <= a; wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'h0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge clk_in);
    rd_in <= 1'h1; addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'h0;
    #1 rd_val = rdata_out;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Bounded wait for a start pulse (0) or interrupt (1); d gets baud ticks
  task automatic wait_for(input int which);
    int t0;
    t0 = ticks;
    for (int i = 0; i < 300; i++) begin
      cyc(1);
      if ((which == 0 && tx_start_out === 1'h1) || (which == 1 && interrupt_out === 1'h1)) break;
    end
    d = ticks - t0;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n_in, wr_in, rd_in, tx_shift_in, stop_done_in, addr_in, wdata_in} = '0;
    on_cmd = 4'h0; rx_cmd = 1'h1;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'h1;
    cyc(1);
    chk("reset pins", {4'h0, modem_out}, 8'h0F);
    chk("reset oe", {7'h0, serial_tx_oe_out}, 8'h01);
    chk("reset int", {7'h0, interrupt_out}, 8'h00);
    rd(3'h0);
    chk("unmapped", rd_val, 8'h00);
    // Ordinary register rows
    foreach (regs[i]) begin
      wr(regs[i].a, regs[i].w);
      rd(regs[i].a);
      chk("readback", rd_val, regs[i].r);
      chk("pins", {4'h0, modem_out}, {4'h0, regs[i].o});
    end
    rd(3'h6);
    wr(3'h1, 8'h08);
    // Change detection, outside and inside loopback
    foreach (modem_status[i]) begin
      if (modem_status[i].a == 3'h0) begin
        @(posedge clk_in);
        on_cmd <= modem_status[i].w[3:0];
      end else wr(3'h4, modem_status[i].w);
      cyc(6);
      if (i == 5) rd(3'h6);
      else begin
        chk("int set", {7'h0, interrupt_out}, {7'h0, |modem_status[i].r[3:0]});
        rd(3'h6);
        chk("status", rd_val, modem_status[i].r);
        cyc(3);
        chk("int clr", {7'h0, interrupt_out}, 8'h00);
      end
    end
    // Host-written status bit in loopback
    wr(3'h6, 8'h04);
    cyc(4);
    chk("int host", {7'h0, interrupt_out}, 8'h01);
    rd(3'h6);
    chk("status host", rd_val, 8'h84);
    chk("loop oe", {7'h0, serial_tx_oe_out}, 8'h00);
    @(posedge clk_in);
    tx_shift_in <= 1'h0; rx_cmd <= 1'h1;
    cyc(1);
    chk("loop rx", {7'h0, rx_shift_out}, 8'h00);
    tx_shift_in <= 1'h1; rx_cmd <= 1'h0;
    cyc(1);
    chk("loop rx", {7'h0, rx_shift_out}, 8'h01);
    // Reprogram before clearing the loop bit
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h00);
    cyc(4);
    chk("oe back", {7'h0, serial_tx_oe_out}, 8'h01);
    chk("rx back", {7'h0, rx_shift_out}, 8'h00);
    chk("masked", {7'h0, interrupt_out}, 8'h00);
    rd(3'h6);
    // Transmit pacing in baud ticks
    wr(3'h1, 8'h02);
    wr(3'h7, 8'h41);
    wait_for(0);
    chk("start ticks", {7'h0, d >= 15 && d <= 17}, 8'h01);
    wait_for(1);
    chk("first int", {7'h0, d >= 7 && d <= 9}, 8'h01);
    wr(3'h7, 8'h42);
    cyc(2);
    chk("int reset", {7'h0, interrupt_out}, 8'h00);
    stop_done_in <= 1'h1;
    @(posedge clk_in);
    stop_done_in <= 1'h0;
    wait_for(1);
    chk("stop ticks", {7'h0, d >= 7 && d <= 9}, 8'h01);
    print_verdict();
  end
endmodule
`default_nettype wire
